// >>> common/ldh_pkg.sv
// Purpose: Shared types and constants for the display driver host port
// Assumes: 8-bit host bus, 100 MHz core clock, serial clock as link clock
// Notes: Pin groups travel as packed structs
`default_nettype none

package ldh_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int DATA_W = 8;
  localparam int STATUS_LOW_W = 7;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [6:0] SHIFT_RESET = 7'h00;

  // ==========================================================================
  // Pin level meanings
  localparam logic MODE_PARALLEL = 1'b1;
  localparam logic STYLE_ENABLE_RW = 1'b1;
  localparam logic SEL_DATA = 1'b1;
  localparam logic SEL_COMMAND = 1'b0;
  localparam int BUSY_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] OE_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic ps;
    logic cs_low_n;
    logic cs_high;
    logic bus_style;
    logic dcs;
    logic rd_strobe;
    logic wr_strobe;
    logic [7:0] data;
  } ldh_pins_type;

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } ldh_item_type;

  localparam ldh_pins_type PINS_RESET = '{
    ps: 1'b0, cs_low_n: 1'b1, cs_high: 1'b0, bus_style: 1'b0, dcs: 1'b0,
    rd_strobe: 1'b1, wr_strobe: 1'b1, data: 8'h00};
  localparam ldh_item_type ITEM_RESET = '{is_data: 1'b0, value: 8'h00};

endpackage

`default_nettype wire

// >>> rtl/ldh_host_port.sv
// Purpose: Host access port of a dot-matrix display driver (parallel and serial)
// Assumes: Parallel pins are asynchronous to clk; serial_clk is the host's clock
// Notes: Received bytes leave through a two-entry buffer with valid and ready
`timescale 1ns/1ps
`default_nettype none

module ldh_host_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic interface_select,
  input wire logic chip_select_low_active_n,
  input wire logic chip_select_high_active,
  input wire logic bus_style_select,
  input wire logic data_command_select,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic [7:0] bus_data_oe,
  input wire logic busy,
  input wire logic [ldh_pkg::STATUS_LOW_W-1:0] status_flags,
  output logic ram_read_req,
  input wire logic ram_read_valid,
  input wire logic [7:0] ram_read_data,
  output ldh_pkg::ldh_item_type item,
  output logic item_valid,
  input wire logic item_ready,
  output logic item_dropped
);
  import ldh_pkg::*;

  // ==========================================================================
  // Link domain: serial receiver
  logic link_clear;
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] link_byte_reg;
  logic link_dcs_reg;
  logic link_toggle_reg;
  logic link_last_bit;

  assign link_clear = (interface_select == MODE_PARALLEL) | chip_select_low_active_n
                      | ~chip_select_high_active;
  assign link_last_bit = (bit_cnt_reg == BIT_CNT_LAST);

  // Cleared at reset as well as whenever the chip is not selected
  always_ff @(posedge serial_clk or posedge link_clear or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SHIFT_RESET;
      bit_cnt_reg <= BIT_CNT_RESET;
    end else if (link_clear) begin
      shift_reg <= SHIFT_RESET;
      bit_cnt_reg <= BIT_CNT_RESET;
    end else begin
      shift_reg <= {shift_reg[5:0], bus_data_in[7]};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_byte_reg <= BYTE_RESET;
      link_dcs_reg <= FLAG_RESET;
      link_toggle_reg <= FLAG_RESET;
    end else if (!link_clear && link_last_bit) begin
      link_byte_reg <= {shift_reg, bus_data_in[7]};
      link_dcs_reg <= data_command_select;
      link_toggle_reg <= ~link_toggle_reg;
    end
  end

  // ==========================================================================
  // Core domain: synchronisers
  ldh_pins_type pins_now;
  ldh_pins_type pins_sync1_reg;
  ldh_pins_type pins_sync2_reg;
  ldh_pins_type pins_prev_reg;
  logic [2:0] tog_sync_reg;

  assign pins_now = '{
    ps: interface_select,
    cs_low_n: chip_select_low_active_n,
    cs_high: chip_select_high_active,
    bus_style: bus_style_select,
    dcs: data_command_select,
    rd_strobe: rd_strobe_n,
    wr_strobe: wr_strobe_n,
    data: bus_data_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_sync1_reg <= PINS_RESET;
      pins_sync2_reg <= PINS_RESET;
      pins_prev_reg <= PINS_RESET;
      tog_sync_reg <= 3'h0;
    end else begin
      pins_sync1_reg <= pins_now;
      pins_sync2_reg <= pins_sync1_reg;
      pins_prev_reg <= pins_sync2_reg;
      tog_sync_reg <= {tog_sync_reg[1:0], link_toggle_reg};
    end
  end

  // ==========================================================================
  // Core domain: parallel decode
  logic sel_now;
  logic sel_prev;
  logic enable_style_now;
  logic enable_style_prev;
  logic read_now;
  logic read_prev;
  logic write_prev;
  logic write_now;
  logic par_write_done;
  logic par_read_done;
  logic serial_byte_done;

  assign sel_now = (pins_sync2_reg.ps == MODE_PARALLEL) & ~pins_sync2_reg.cs_low_n
                   & pins_sync2_reg.cs_high;
  assign sel_prev = (pins_prev_reg.ps == MODE_PARALLEL) & ~pins_prev_reg.cs_low_n
                    & pins_prev_reg.cs_high;
  assign enable_style_now = (pins_sync2_reg.bus_style == STYLE_ENABLE_RW);
  assign enable_style_prev = (pins_prev_reg.bus_style == STYLE_ENABLE_RW);
  assign read_now = sel_now & (enable_style_now ?
                    (pins_sync2_reg.rd_strobe & pins_sync2_reg.wr_strobe) :
                    ~pins_sync2_reg.rd_strobe);
  assign read_prev = sel_prev & (enable_style_prev ?
                     (pins_prev_reg.rd_strobe & pins_prev_reg.wr_strobe) :
                     ~pins_prev_reg.rd_strobe);
  assign write_now = sel_now & (enable_style_now ?
                     (pins_sync2_reg.rd_strobe & ~pins_sync2_reg.wr_strobe) :
                     ~pins_sync2_reg.wr_strobe);
  assign write_prev = sel_prev & (enable_style_prev ?
                      (pins_prev_reg.rd_strobe & ~pins_prev_reg.wr_strobe) :
                      ~pins_prev_reg.wr_strobe);
  assign par_write_done = write_prev & ~write_now;
  assign par_read_done = read_prev & ~read_now;
  assign serial_byte_done = tog_sync_reg[2] ^ tog_sync_reg[1];

  // ==========================================================================
  // Core domain: read path
  logic [7:0] status_byte;
  logic [7:0] holder_reg;
  logic [7:0] read_value;
  logic fetch_req;
  logic [7:0] data_out_reg;
  logic [7:0] data_oe_reg;
  logic ram_read_req_reg;

  assign status_byte = {busy, status_flags};
  assign read_value = (pins_sync2_reg.dcs == SEL_DATA) ? holder_reg : status_byte;
  assign fetch_req = par_read_done & (pins_prev_reg.dcs == SEL_DATA) & ~busy;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out_reg <= BYTE_RESET;
      data_oe_reg <= OE_RESET;
      ram_read_req_reg <= FLAG_RESET;
      holder_reg <= BYTE_RESET;
    end else begin
      data_out_reg <= read_value;
      data_oe_reg <= {DATA_W{read_now}};
      ram_read_req_reg <= fetch_req;
      if (ram_read_valid) begin
        holder_reg <= ram_read_data;
      end
    end
  end

  // ==========================================================================
  // Core domain: write capture
  ldh_item_type new_item;
  ldh_item_type serial_item;
  ldh_item_type par_item;
  logic new_valid;
  logic new_blocked;
  ldh_item_type pend_reg;
  ldh_item_type pend_next;
  logic pend_valid_reg;
  logic pend_valid_next;
  logic dropped_reg;
  logic dropped_next;
  logic fifo_in_ready;
  logic push;

  assign serial_item = '{is_data: (link_dcs_reg == SEL_DATA),
                         value: link_byte_reg};
  assign par_item = '{is_data: (pins_prev_reg.dcs == SEL_DATA),
                      value: pins_prev_reg.data};
  // Byte source: serial wins, the two modes never overlap
  assign new_item = serial_byte_done ? serial_item : par_item;
  assign new_blocked = busy & ~new_item.is_data;
  assign new_valid = (serial_byte_done | par_write_done) & ~new_blocked;
  assign push = pend_valid_reg & fifo_in_ready;

  always_comb begin
    pend_next = pend_reg;
    pend_valid_next = pend_valid_reg & ~push;
    dropped_next = (serial_byte_done | par_write_done) & new_blocked;
    if (new_valid) begin
      if (pend_valid_next) begin
        dropped_next = 1'b1;
      end else begin
        pend_next = new_item;
        pend_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg <= ITEM_RESET;
      pend_valid_reg <= FLAG_RESET;
      dropped_reg <= FLAG_RESET;
    end else begin
      pend_reg <= pend_next;
      pend_valid_reg <= pend_valid_next;
      dropped_reg <= dropped_next;
    end
  end

  // ==========================================================================
  // Core domain: two-entry output buffer
  ldh_item_type head_reg;
  ldh_item_type head_next;
  ldh_item_type tail_reg;
  ldh_item_type tail_next;
  logic head_valid_reg;
  logic head_valid_next;
  logic tail_valid_reg;
  logic tail_valid_next;
  logic pop;

  assign pop = head_valid_reg & item_ready;
  assign fifo_in_ready = ~tail_valid_reg;

  always_comb begin
    head_next = head_reg;
    tail_next = tail_reg;
    head_valid_next = head_valid_reg;
    tail_valid_next = tail_valid_reg;
    if (pop) begin
      head_next = tail_reg;
      head_valid_next = tail_valid_reg;
      tail_valid_next = 1'b0;
    end
    if (push) begin
      if (!head_valid_next) begin
        head_next = pend_reg;
        head_valid_next = 1'b1;
      end else begin
        tail_next = pend_reg;
        tail_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_reg <= ITEM_RESET;
      tail_reg <= ITEM_RESET;
      head_valid_reg <= FLAG_RESET;
      tail_valid_reg <= FLAG_RESET;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      head_valid_reg <= head_valid_next;
      tail_valid_reg <= tail_valid_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign bus_data_out = data_out_reg;
  assign bus_data_oe = data_oe_reg;
  assign ram_read_req = ram_read_req_reg;
  assign item = head_reg;
  assign item_valid = head_valid_reg;
  assign item_dropped = dropped_reg;

endmodule // ldh_host_port

`default_nettype wire

// >>> sim/ldh_host_model.sv
// Purpose: Host processor model for the display host port
// Assumes: Parallel cycles paced by clk, serial clock period 32 ns
// Notes: Released data pins show the inverse of the last parallel byte, data[7] the inverse of the last serial bit
`timescale 1ns/1ps
`default_nettype none
module ldh_host_model (
  input wire logic clk,
  input wire logic [7:0] bus,
  output var logic sclk,
  output var ldh_pkg::ldh_pins_type pin
);
  import ldh_pkg::*;
  // ==========
  // Parallel cycle, a read when rw is high
  initial {sclk, pin} = {1'b0, PINS_RESET};
  task automatic par(input logic sel, st, rw, a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    pin <= '{1'b1, 1'b0, sel, st, a, !st, st ? rw : 1'b1, d};
    repeat (4) @(posedge clk);
    {pin.rd_strobe, pin.wr_strobe} <= st ? {1'b1, rw} : {!rw, rw};
    repeat (8) @(posedge clk);
    q = bus;
    {pin.rd_strobe, pin.wr_strobe} <= {!st, st ? rw : 1'b1};
    repeat (8) @(posedge clk);
    pin.data <= ~d;
  endtask
  // ==========
  // Serial byte of n bits, deselected when cut short
  task automatic ser(input logic a, input logic [7:0] d, input int n);
    @(negedge clk);
    {pin.ps, pin.cs_low_n, pin.cs_high} = 3'b001;
    #64;
    for (int i = 7; i > 7 - n; i--) begin
      pin.data[7] = d[i];
      pin.dcs = (i == 0) ? a : !a;
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    pin.data[7] = !pin.data[7];
    if (n < 8) pin.cs_high = 1'b0;
    #40;
  endtask
endmodule // ldh_host_model
`default_nettype wire

// >>> sim/ldh_host_port_properties.sv
// Purpose: Port checker for the display host port
// Assumes: Sees only the top module's ports
// Notes: Bound into every instance of the port
`timescale 1ns/1ps
`default_nettype none
module ldh_host_port_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic chip_select_low_active_n,
  input wire logic chip_select_high_active,
  input wire logic item_ready,
  input wire logic [7:0] bus_data_oe,
  input wire logic ram_read_req,
  input wire ldh_pkg::ldh_item_type item,
  input wire logic item_valid,
  input wire logic item_dropped
);
  import ldh_pkg::*;
  // ==========
  // Port relations
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  oe_serial_a: assert property (!interface_select [*4] |-> bus_data_oe == 8'h00)
    else $error("pins driven in serial mode");
  oe_deselect_a: assert property (
    (chip_select_low_active_n || !chip_select_high_active) [*4] |-> bus_data_oe == 8'h00)
    else $error("pins driven while deselected");
  oe_whole_a: assert property (bus_data_oe == 8'h00 || bus_data_oe == 8'hFF)
    else $error("partial byte driven");
  read_selected_a: assert property ($rose(bus_data_oe[0]) |-> interface_select
    && !chip_select_low_active_n && chip_select_high_active) else $error("read unselected");
  serial_read_a: assert property (!interface_select [*6] |-> !ram_read_req)
    else $error("fetch in serial mode");
  drop_pulse_a: assert property (item_dropped |=> !item_dropped)
    else $error("drop pulse too long");
  req_pulse_a: assert property (ram_read_req |=> !ram_read_req)
    else $error("fetch pulse too long");
  item_hold_a: assert property (item_valid && !item_ready |=> item_valid && $stable(item))
    else $error("item lost before accept");
endmodule // ldh_host_port_properties
bind ldh_host_port ldh_host_port_properties u_props (.clk, .rst_n, .interface_select,
  .chip_select_low_active_n, .chip_select_high_active, .item_ready, .bus_data_oe,
  .ram_read_req, .item, .item_valid, .item_dropped);
`default_nettype wire

// >>> sim/ldh_host_port_test.sv
// Purpose: Self-checking bench for the display host port
// Assumes: Host model drives the pins, bench plays RAM side and item sink
// Notes: Each test is a sequence of host cycles with expected values
`timescale 1ns/1ps
`default_nettype none
module ldh_host_port_test;
  import ldh_pkg::*;
  localparam logic [7:0] RAM_VAL = 8'hC3;
  localparam logic [6:0] FLAGS = 7'h2A;
  logic clk = 1'b0, rst_n = 1'b1, busy = 1'b0, item_ready = 1'b0, ram_read_valid = 1'b0;
  logic serial_clk, ram_read_req, item_valid, item_dropped;
  logic [7:0] bus_data_in, bus_data_out, bus_data_oe, q;
  ldh_pins_type pin;
  ldh_item_type item;
  int bad_count = 0, compares = 0, drops = 0;
  // ==========
  // Clock, pin resolution and RAM side
  always #5 clk = ~clk;
  assign bus_data_in = bus_data_oe[0] ? bus_data_out
    : pin.ps ? pin.data : {pin.data[7], serial_clk, ~pin.data[5:0]};
  always @(posedge clk) ram_read_valid <= ram_read_req;
  always @(posedge clk) drops <= drops + int'(item_dropped === 1'b1);
  ldh_host_model host (.clk, .bus(bus_data_in), .sclk(serial_clk), .pin);
  ldh_host_port dut (.clk, .rst_n, .serial_clk, .interface_select(pin.ps),
    .chip_select_low_active_n(pin.cs_low_n), .chip_select_high_active(pin.cs_high),
    .bus_style_select(pin.bus_style), .data_command_select(pin.dcs),
    .rd_strobe_n(pin.rd_strobe), .wr_strobe_n(pin.wr_strobe), .bus_data_in,
    .bus_data_out, .bus_data_oe, .busy, .status_flags(FLAGS), .ram_read_req,
    .ram_read_valid, .ram_read_data(RAM_VAL), .item, .item_valid, .item_ready,
    .item_dropped);
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic take(input logic [8:0] exp);
    @(posedge clk);
    for (int k = 0; k < 80 && item_valid !== 1'b1; k++) @(posedge clk);
    chk("item", item_valid === 1'b1 ? 9'(item) : 9'h1FF, exp);
    item_ready <= 1'b1;
    @(posedge clk);
    item_ready <= 1'b0;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      host.par(1'b1, i[1], 1'b0, i[0], 8'h90 + 8'(i), q);
      take({i[0], 8'h90 + 8'(i)});
    end
    $display("test styles done");
    for (int i = 0; i < 4; i++) host.par(1'b1, 1'b0, 1'b0, 1'b1, 8'h40 + 8'(i), q);
    chk("drops", 9'(drops), 9'h001);
    for (int i = 0; i < 3; i++) take({1'b1, 8'h40 + 8'(i)});
    $display("test buffer done");
    busy <= 1'b1;
    host.par(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, q);
    chk("status", {1'b0, q}, {2'b01, FLAGS});
    host.par(1'b1, 1'b1, 1'b0, 1'b0, 8'h12, q);
    chk("drops", 9'(drops), 9'h002);
    host.par(1'b1, 1'b1, 1'b0, 1'b1, 8'h34, q);
    take({1'b1, 8'h34});
    busy <= 1'b0;
    host.par(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, q);
    chk("status", {1'b0, q}, {2'b00, FLAGS});
    $display("test busy done");
    host.par(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("dummy", {1'b0, q}, {1'b0, BYTE_RESET});
    host.par(1'b1, 1'b0, 1'b1, 1'b1, 8'h00, q);
    chk("ram", {1'b0, q}, {1'b0, RAM_VAL});
    $display("test dummy read done");
    host.ser(1'b1, 8'hB2, 8);
    host.ser(1'b0, 8'h1E, 8);
    take({1'b1, 8'hB2});
    take({1'b0, 8'h1E});
    host.ser(1'b1, 8'hFF, 3);
    host.ser(1'b1, 8'h47, 8);
    take({1'b1, 8'h47});
    $display("test serial done");
    host.par(1'b0, 1'b0, 1'b0, 1'b1, 8'h55, q);
    repeat (20) @(posedge clk);
    chk("ignored", {8'h00, item_valid}, 9'h000);
    host.par(1'b0, 1'b0, 1'b1, 1'b1, 8'h55, q);
    chk("float", {1'b0, q}, 9'h055);
    $display("test deselect done");
    test_done;
  end
  initial begin
    #100000 bad_count++;
    test_done;
  end
endmodule // ldh_host_port_test
`default_nettype wire
